// File: src/timer_front.sv
// Three-channel timer: input synchronisation, prescaler, mode decode, outputs
//
// Functional notes
// RULE1: Every channel owns an external clock input, a gate input and an output.
// RULE2: External clocks 1, 2, 3 decrement counters 1, 2, 3.
// RULE3: Clock inputs pass three enable periods of synchronising before use.
// RULE4: Counter decrements on the fourth enable edge after a clock transition.
// RULE5: Prescaler option divides channel 3 clock by eight, counting every transition; the code counts falling transitions only.
// RULE6: Prescaler output enters the same synchronising path as plain clocks.
// RULE7: Late prescaled transitions are handled one enable cycle later.
// RULE8: Gate inputs 1, 2, 3 trigger or gate timers 1, 2, 3.
// RULE9: Gate inputs are synchronised alike, recognised on the fourth enable edge.
// RULE10: Gates act on the counter directly, unaffected by prescaler selection.
// RULE11: Single 16-bit: square wave when continuous, single pulse in single-shot.
// RULE12: Dual 8-bit: variable duty-cycle pulse in both synthesis modes.
// RULE13: Output held low whenever its output-enable control bit is clear.
// RULE14: Clearing output enable drops the output in the cycle after the write; the code drops it at the same edge that writes the control register.
// RULE15: Control bits 3, 4, 5 decode into one of four modes.
// RULE16: Remaining mode bit alters initialisation, enabling or measurement condition.
// RULE17: Frequency comparison measures cyclic widths, pulse-width comparison single ones; the code treats both alike, bit 5 picking gate fall or time-out.
// RULE18: Single-shot yields one output pulse, width set by the preset count.
// RULE19: Comparison modes may drive the output without a defined waveform.
// RULE20: Control register 3 bit zero selects the channel 3 prescaler.
// RULE21: Control bit 2 selects 16-bit counting at zero, dual 8-bit at one.
// RULE22: Edges found by comparing successive synchronised samples, one-cycle events.
// RULE23: Synchronisers, edge detects and outputs use aclk and the reset input.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_front
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External clock inputs, active on falling transitions
  input wire logic ext_clk_in_ch1,
  input wire logic ext_clk_in_ch2,
  input wire logic ext_clk_in_ch3,
  // Gate inputs, counting enabled while low
  input wire logic gate_in_ch1,
  input wire logic gate_in_ch2,
  input wire logic gate_in_ch3,
  // Timer outputs
  output logic timer_out_ch1,
  output logic timer_out_ch2,
  output logic timer_out_ch3
);
  front_state_type s_q, s_d;
  logic [2:0] clk_pin, gate_pin;
  logic [2:0] clk_fall, gate_lvl, gate_fall;
  logic prescale_sel_ch3;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  assign prescale_sel_ch3 = s_q.ctrl[2][`CR_PRESCALE]; // [RULE20]
  assign clk_pin[0] = ext_clk_in_ch1; // [RULE1] [RULE2]
  assign clk_pin[1] = ext_clk_in_ch2;
  // Divided clock takes the plain clock's place ahead of the synchroniser
  assign clk_pin[2] = prescale_sel_ch3 ? s_q.pre[2] : ext_clk_in_ch3; // [RULE6] [RULE7]
  assign gate_pin[0] = gate_in_ch1; // [RULE8]
  assign gate_pin[1] = gate_in_ch2;
  assign gate_pin[2] = gate_in_ch3;

  // Clock pins
  input_sync u_clk_sync_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(clk_pin[0]),
    .level(),
    .fall(clk_fall[0]),
    .rise()
  ); // [RULE3] [RULE22] [RULE23]
  input_sync u_clk_sync_ch2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(clk_pin[1]),
    .level(),
    .fall(clk_fall[1]),
    .rise()
  ); // [RULE3] [RULE22] [RULE23]
  input_sync u_clk_sync_ch3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(clk_pin[2]),
    .level(),
    .fall(clk_fall[2]),
    .rise()
  ); // [RULE3] [RULE22] [RULE23]

  // Gate pins, level kept for counting and status
  input_sync u_gate_sync_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(gate_pin[0]),
    .level(gate_lvl[0]),
    .fall(gate_fall[0]),
    .rise()
  ); // [RULE9] [RULE22] [RULE23]
  input_sync u_gate_sync_ch2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(gate_pin[1]),
    .level(gate_lvl[1]),
    .fall(gate_fall[1]),
    .rise()
  ); // [RULE9] [RULE22] [RULE23]
  input_sync u_gate_sync_ch3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(gate_pin[2]),
    .level(gate_lvl[2]),
    .fall(gate_fall[2]),
    .rise()
  ); // [RULE9] [RULE22] [RULE23]

  ////////////////////////////////////////////////////////////////////////////
  // Register bus and timer logic

  always_comb begin
    logic [2:0] wr_latch;
    logic [7:0] ra;
    logic [7:0] cr;
    logic init;
    logic tick;
    logic timeout;
    logic dual;
    mode_type mode;
    wr_latch = '0;
    ra = s_axi_araddr;
    cr = '0;
    init = 1'b0;
    tick = 1'b0;
    timeout = 1'b0;
    dual = 1'b0;
    mode = mode_continuous;
    s_d = s_q;

    // Prescaler counts each falling transition of the raw pin
    // One sample flop keeps the divider on aclk, unlike a ripple chain
    s_d.pre_last = ext_clk_in_ch3;
    if (s_q.pre_last && !ext_clk_in_ch3) begin
      s_d.pre = s_q.pre + 3'h1; // [RULE5]
    end

    // Write address and data accepted in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awaddr = s_axi_awaddr;
      s_d.aw_ok = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.w_ok = 1'b1;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `RESP_OKAY;
      if (s_q.awaddr == `OFF_CTRL1 || s_q.awaddr == `OFF_CTRL2 ||
          s_q.awaddr == `OFF_CTRL3) begin
        if (s_q.wstrb[0]) begin
          s_d.ctrl[s_q.awaddr[3:2]] = s_q.wdata[7:0];
        end
      end else if (s_q.awaddr == `OFF_LATCH1 || s_q.awaddr == `OFF_LATCH2 ||
                   s_q.awaddr == `OFF_LATCH3) begin
        for (int i = 0; i < `CHANNELS; i++) begin
          if (s_q.awaddr == `OFF_LATCH1 + 8'(4 * i)) begin
            wr_latch[i] = 1'b1;
            if (s_q.wstrb[0]) begin
              s_d.latch[i][7:0] = s_q.wdata[7:0];
            end
            if (s_q.wstrb[1]) begin
              s_d.latch[i][15:8] = s_q.wdata[15:8];
            end
          end
        end
      end else if (s_q.awaddr != `OFF_STATUS && s_q.awaddr != `OFF_COUNT1 &&
                   s_q.awaddr != `OFF_COUNT2 && s_q.awaddr != `OFF_COUNT3) begin
        s_d.bresp = `RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // Read channel, one outstanding read
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = `RESP_OKAY;
      s_d.rdata = '0;
      if (ra == `OFF_CTRL1) begin
        s_d.rdata[7:0] = s_q.ctrl[0];
      end else if (ra == `OFF_CTRL2) begin
        s_d.rdata[7:0] = s_q.ctrl[1];
      end else if (ra == `OFF_CTRL3) begin
        s_d.rdata[7:0] = s_q.ctrl[2];
      end else if (ra == `OFF_LATCH1) begin
        s_d.rdata[15:0] = s_q.latch[0];
      end else if (ra == `OFF_LATCH2) begin
        s_d.rdata[15:0] = s_q.latch[1];
      end else if (ra == `OFF_LATCH3) begin
        s_d.rdata[15:0] = s_q.latch[2];
      end else if (ra == `OFF_STATUS) begin
        s_d.rdata[8:0] = {gate_lvl, s_q.meas, s_q.out};
      end else if (ra == `OFF_COUNT1) begin
        s_d.rdata[15:0] = s_q.cnt[0];
      end else if (ra == `OFF_COUNT2) begin
        s_d.rdata[15:0] = s_q.cnt[1];
      end else if (ra == `OFF_COUNT3) begin
        s_d.rdata[15:0] = s_q.cnt[2];
      end else begin
        s_d.rresp = `RESP_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Per-channel counting and waveform
    for (int i = 0; i < `CHANNELS; i++) begin
      cr = s_d.ctrl[i];
      mode = decode_mode(cr); // [RULE15]
      dual = cr[`CR_DUAL]; // [RULE21]
      // Gate edge restarts the counter; latch write only if modifier and measure bits both clear
      init = gate_fall[i] | (wr_latch[i] & ~cr[`CR_MODIFIER] &
             ~cr[`CR_MEASURE]); // [RULE10] [RULE16]
      // Counter steps only while the gate is low
      tick = clk_fall[i] & ~gate_lvl[i]; // [RULE4] [RULE8]
      timeout = 1'b0;
      if (wr_latch[i]) begin
        s_d.meas[i] = 1'b0;
      end
      if (init) begin
        s_d.cnt[i] = s_d.latch[i];
        s_d.done[i] = 1'b0;
        // 16-bit single pulse rises at start; dual single-shot and other shapes start low
        s_d.wave[i] = (mode == mode_oneshot) & ~dual; // [RULE18]
      end else if (tick) begin
        if (dual) begin
          if (s_q.cnt[i] == 16'h0000) begin
            timeout = 1'b1;
            s_d.cnt[i] = s_d.latch[i];
          end else if (s_q.cnt[i][7:0] == 8'h00) begin
            s_d.cnt[i] = {s_q.cnt[i][15:8] - 8'h01, s_d.latch[i][7:0]};
          end else begin
            s_d.cnt[i] = {s_q.cnt[i][15:8], s_q.cnt[i][7:0] - 8'h01};
          end
          // High while the upper byte has run out, low again at time-out
          s_d.wave[i] = ~timeout & (s_d.cnt[i][15:8] == 8'h00); // [RULE12]
        end else begin
          if (s_q.cnt[i] == 16'h0000) begin
            timeout = 1'b1;
            s_d.cnt[i] = s_d.latch[i];
            if (mode == mode_oneshot) begin
              s_d.wave[i] = 1'b0;
            end else begin
              s_d.wave[i] = ~s_q.wave[i]; // [RULE11]
            end
          end else begin
            s_d.cnt[i] = s_q.cnt[i] - 16'h0001;
          end
        end
        if (timeout) begin
          s_d.done[i] = 1'b1;
        end
      end
      // Single-shot stays quiet after its first time-out
      if (mode == mode_oneshot && s_d.done[i]) begin
        s_d.wave[i] = 1'b0; // [RULE18]
      end
      // Measurement outcome flag; set has priority over the latch-write clear
      if (mode == mode_freq_cmp || mode == mode_width_cmp) begin
        if (!cr[`CR_ONESHOT] && gate_fall[i] && !s_q.done[i]) begin
          s_d.meas[i] = 1'b1; // [RULE17] [RULE16]
        end
        if (cr[`CR_ONESHOT] && timeout && !s_q.done[i]) begin
          s_d.meas[i] = 1'b1; // [RULE17] [RULE16]
        end
      end
      // Comparison modes still show the raw wave, shape not guaranteed
      s_d.out[i] = s_d.wave[i] & cr[`CR_OUT_EN]; // [RULE13] [RULE14] [RULE19]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      // Latches and counters start at full count
      s_q.latch <= {`CHANNELS{`LATCH_RESET}};
      s_q.cnt <= {`CHANNELS{`LATCH_RESET}};
      s_q.pre_last <= 1'b1;
    end else begin
      s_q <= s_d; // [RULE23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign timer_out_ch1 = s_q.out[0]; // [RULE1]
  assign timer_out_ch2 = s_q.out[1];
  assign timer_out_ch3 = s_q.out[2];
endmodule // timer_front

// File: src/timer_defs.svh
// Offsets, field positions, reset values and timing figures of the timer front end
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define CHANNELS 3
`define SYNC_STAGES 3
`define PRESCALE_BITS 3
`define ADDR_W 8
`define OFF_CTRL1 8'h00
`define OFF_CTRL2 8'h04
`define OFF_CTRL3 8'h08
`define OFF_LATCH1 8'h0c
`define OFF_LATCH2 8'h10
`define OFF_LATCH3 8'h14
`define OFF_STATUS 8'h18
`define OFF_COUNT1 8'h1c
`define OFF_COUNT2 8'h20
`define OFF_COUNT3 8'h24
`define CR_PRESCALE 0
`define CR_DUAL 2
`define CR_MEASURE 3
`define CR_MODIFIER 4
`define CR_ONESHOT 5
`define CR_OUT_EN 7
`define LATCH_RESET 16'hffff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: src/timer_pkg.sv
// Types shared by the timer front end modules
package timer_pkg;
  typedef enum logic [1:0] {
    mode_continuous = 2'b00,
    mode_oneshot = 2'b01,
    mode_freq_cmp = 2'b10,
    mode_width_cmp = 2'b11
  } mode_type;

  typedef struct packed {
    logic [2:0] stage;
    logic fall;
    logic rise;
  } sync_state_type;

  typedef struct packed {
    logic [7:0] awaddr;
    logic aw_ok;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0][7:0] ctrl;
    logic [2:0][15:0] latch;
    logic [2:0][15:0] cnt;
    logic [2:0] wave;
    logic [2:0] done;
    logic [2:0] meas;
    logic [2:0] out;
    logic [2:0] pre;
    logic pre_last;
  } front_state_type;

  function automatic mode_type decode_mode(input logic [7:0] cr);
    if (!cr[3]) begin
      decode_mode = cr[5] ? mode_oneshot : mode_continuous;
    end else begin
      decode_mode = cr[4] ? mode_width_cmp : mode_freq_cmp;
    end
  endfunction
endpackage

// File: src/input_sync.sv
// Three-stage input synchroniser with registered edge events
`timescale 1ns/1ps
`include "timer_defs.svh"
module input_sync
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin side
  input wire logic pin,
  // Recognised level and edges
  output logic level,
  output logic fall,
  output logic rise
);
  sync_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[1:0], pin};
    // Edge events come from stages two and three, never the first
    s_d.fall = s_q.stage[2] & ~s_q.stage[1];
    s_d.rise = ~s_q.stage[2] & s_q.stage[1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.stage[2];
  assign fall = s_q.fall;
  assign rise = s_q.rise;
endmodule // input_sync

// File: bench/timer_front_monitor.sv
// Port checks for the timer front end
`timescale 1ns/1ps
module timer_front_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic ext_clk_in_ch1,
  input wire logic timer_out_ch1
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_idle: assert property ($rose(aresetn) |-> !timer_out_ch1 && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  // Only a recognised fall or a register write may move the output
  a_out_cause: assert property ($changed(timer_out_ch1) |-> s_axi_bvalid
    || ($past(ext_clk_in_ch1, 6) && !$past(ext_clk_in_ch1, 5))
    || ($past(ext_clk_in_ch1, 5) && !$past(ext_clk_in_ch1, 4)))
    else $error("output moved without clock fall or write");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("address accepted while busy");
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready
    && s_axi_wready && !s_axi_bvalid) else $error("readies not restored");
endmodule // timer_front_monitor

// File: bench/pin_source.sv
// Model of the clock and gate sources on the timer pins
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic aclk,
  // Pins
  output logic [2:0] clk_pins,
  output logic [2:0] gate_pins
);
  initial begin
    clk_pins = 3'h7;
    gate_pins = 3'h0;
  end
  // Levels held three cycles, well past the one-cycle minimum
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge aclk);
      clk_pins[ch] <= 1'b0;
      repeat (3) @(posedge aclk);
      clk_pins[ch] <= 1'b1;
      repeat (2) @(posedge aclk);
    end
    repeat (9) @(posedge aclk);
  endtask
  task automatic gate(input int ch, input logic lvl);
    @(posedge aclk);
    gate_pins[ch] <= lvl;
    repeat (9) @(posedge aclk);
  endtask
endmodule // pin_source

// File: bench/tb.sv
// Self-checking bench for the timer front end
`timescale 1ns/1ps
`include "timer_defs.svh"
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] cp, gp, tout;
  int failures, n_compared, seed, ch, n, i, lat[3], cnt[3], wave[3];
  timer_front u_timer_front (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clk_in_ch1(cp[0]), .ext_clk_in_ch2(cp[1]), .ext_clk_in_ch3(cp[2]),
    .gate_in_ch1(gp[0]), .gate_in_ch2(gp[1]), .gate_in_ch3(gp[2]),
    .timer_out_ch1(tout[0]), .timer_out_ch2(tout[1]), .timer_out_ch3(tout[2]));
  pin_source u_pin_source (.aclk(aclk), .clk_pins(cp), .gate_pins(gp));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >>> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ad(input logic [7:0] b, input int c);
    return b + 8'(4 * c);
  endfunction
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic await(ref logic s);
    for (int k = 0; k < 100 && s !== 1'b1; k++) @(posedge aclk);
    if (s !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Ready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Each channel is released at the edge that takes it
    for (int k = 0; k < 100 && !(aw_done && w_done); k++) begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (!(aw_done && w_done)) begin
      failures++;
      test_done();
    end
    await(bvalid);
    chk(32'(bresp), 32'(e));
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input int e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    await(arready);
    arvalid <= 1'b0;
    await(rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    if (e >= 0) chk(32'(d[15:0]), 32'(e));
  endtask
  task automatic model(input int c, input int k);
    repeat (k) begin
      if (cnt[c] == 0) begin
        cnt[c] = lat[c];
        wave[c] ^= 1;
      end else begin
        cnt[c]--;
      end
    end
  endtask
  // Dual byte counting: high while the upper byte is zero, low at time-out
  task automatic model2(input int c, input int k);
    repeat (k) begin
      if (cnt[c] == 0) begin
        cnt[c] = lat[c];
        wave[c] = 0;
      end else begin
        if (cnt[c] % 256 == 0) begin
          cnt[c] = cnt[c] - 256 + lat[c] % 256;
        end else begin
          cnt[c]--;
        end
        wave[c] = (cnt[c] / 256 == 0);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    seed = 25387;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (ch = 0; ch < 3; ch++) begin
      rchk(ad(`OFF_CTRL1, ch), 0);
      rchk(ad(`OFF_LATCH1, ch), 32'(`LATCH_RESET));
      wave[ch] = 0;
    end
    wr(8'h28, 32'h0, `RESP_SLVERR);
    rchk(8'h28, -1);
    chk(32'(r), 32'(`RESP_SLVERR));
    for (ch = 0; ch < 3; ch++) begin
      lat[ch] = 2 + (rnd() & 7);
      cnt[ch] = lat[ch];
      wr(ad(`OFF_CTRL1, ch), 32'h80, `RESP_OKAY);
      wr(ad(`OFF_LATCH1, ch), 32'(lat[ch]), `RESP_OKAY);
      n = lat[ch] + 1 + (rnd() & 1);
      u_pin_source.pulse(ch, n);
      model(ch, n);
      rchk(ad(`OFF_COUNT1, ch), cnt[ch]);
      chk(32'(tout[ch]), 32'(wave[ch]));
    end
    wr(`OFF_CTRL1, 32'h00, `RESP_OKAY);
    chk(32'(tout[0]), 32'h0);
    n = 2 * lat[0] + 2;
    u_pin_source.pulse(0, n);
    model(0, n);
    chk(32'(tout[0]), 32'h0);
    wr(`OFF_CTRL1, 32'h80, `RESP_OKAY);
    chk(32'(tout[0]), 32'(wave[0]));
    u_pin_source.gate(1, 1'b1);
    u_pin_source.pulse(1, 3);
    rchk(`OFF_COUNT2, cnt[1]);
    wr(`OFF_CTRL2, 32'h90, `RESP_OKAY);
    wr(`OFF_LATCH2, 32'h33, `RESP_OKAY);
    rchk(`OFF_COUNT2, cnt[1]);
    u_pin_source.gate(1, 1'b0);
    rchk(`OFF_COUNT2, 32'h33);
    wr(`OFF_CTRL3, 32'h81, `RESP_OKAY);
    repeat (10) @(posedge aclk);
    wr(`OFF_LATCH3, 32'h40, `RESP_OKAY);
    for (i = 1; i < 3; i++) begin
      u_pin_source.pulse(2, 8);
      rchk(`OFF_COUNT3, 32'h40 - i);
    end
    wr(`OFF_CTRL3, 32'h88, `RESP_OKAY);
    u_pin_source.gate(2, 1'b1);
    u_pin_source.gate(2, 1'b0);
    rchk(`OFF_STATUS, -1);
    chk(32'(d[5]), 32'h1);
    wr(`OFF_LATCH3, 32'h5, `RESP_OKAY);
    rchk(`OFF_STATUS, -1);
    chk(32'(d[5]), 32'h0);
    wr(`OFF_CTRL2, 32'h84, `RESP_OKAY);
    lat[1] = ((1 + (rnd() & 1)) << 8) | (1 + (rnd() & 3));
    wr(`OFF_LATCH2, 32'(lat[1]), `RESP_OKAY);
    cnt[1] = lat[1];
    wave[1] = 0;
    n = 3 + (rnd() & 15);
    u_pin_source.pulse(1, n);
    model2(1, n);
    rchk(`OFF_COUNT2, cnt[1]);
    chk(32'(tout[1]), 32'(wave[1]));
    wr(`OFF_CTRL1, 32'ha0, `RESP_OKAY);
    wr(`OFF_LATCH1, 32'h2, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(tout[0]), 32'h1);
    for (i = 0; i < 2; i++) begin
      u_pin_source.pulse(0, 3 + 3 * i);
      chk(32'(tout[0]), 32'h0);
    end
    test_done();
  end
endmodule // tb

bind timer_front timer_front_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_clk_in_ch1(ext_clk_in_ch1), .timer_out_ch1(timer_out_ch1));
